// >>> logic/pid_aux_pkg.sv
/*
 * Package for the loop-mode and alarm logic around the process controller.
 * Holds widths, reset values, analog routing selections and timing constants.
 * Assumes signed two's complement process quantities of a common width.
 */
package pid_aux_pkg;

    localparam int UPDATE_NS_DEF       = 1000;
    localparam int CLK_NS              = 8;
    localparam int UPDATE_CYCLES_DEF   = (UPDATE_NS_DEF + CLK_NS - 1) / CLK_NS;
    localparam int DATA_W_DEF          = 16;
    localparam logic RST_CLOSED_LOOP   = 1'b0;
    localparam logic RST_FLAG          = 1'b0;

    typedef enum logic [1:0]
    {
        ROUTE_CTRL_OUT = 2'b00,
        ROUTE_MEASURED = 2'b01,
        ROUTE_INTEG    = 2'b10
    } route_e;

    typedef enum logic [1:0]
    {
        INTEG_RUN    = 2'b00,
        INTEG_HOLD_H = 2'b01,
        INTEG_HOLD_L = 2'b10
    } integ_e;

endpackage

// >>> logic/pid_flags_if.sv
/*
 * Interface carrying the comparison flags from the comparator to the top.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface pid_flags_if;
    logic out_hi;
    logic out_lo;
    logic proc_hi;
    logic proc_lo;
    modport src (output out_hi, output out_lo, output proc_hi, output proc_lo);
    modport dst (input out_hi, input out_lo, input proc_hi, input proc_lo);
endinterface

// >>> logic/pid_compare.sv
/*
 * Combinational threshold comparator for output clamps and process alarms.
 * Assumes signed operands of equal width; results are registered by the top.
 */
`timescale 1ns/10ps
module pid_compare
    import pid_aux_pkg::*;
#(
    parameter int W = DATA_W_DEF
)
(
    // Operands
    input  wire logic signed [W-1:0] ctrl_out,
    input  wire logic signed [W-1:0] measured,
    input  wire logic signed [W-1:0] out_upper,
    input  wire logic signed [W-1:0] out_lower,
    input  wire logic signed [W-1:0] high_thresh,
    input  wire logic signed [W-1:0] low_thresh,
    // Results
    pid_flags_if.src                 flags
);
    // Clamp limits are inclusive, alarms are strict
    assign flags.out_hi  = (ctrl_out >= out_upper);
    assign flags.out_lo  = (ctrl_out <= out_lower);
    assign flags.proc_hi = (measured > high_thresh);
    assign flags.proc_lo = (measured < low_thresh);
endmodule

// >>> logic/pid_loop_mode_and_alarms.sv
/*
 * Loop mode selection, bias, output inversion, integrator anti-windup and
 * alarm flags around a process controller. The PID arithmetic is outside;
 * it supplies the proportional/derivative sum and error each cycle.
 * Assumes all inputs synchronous to CLK.
 */
// Overview of operation
// [RULE1] Bias input is added to the controller sum to set the operating point.
// [RULE2] External option on: closed loop needs closed button and external enable.
// [RULE3] External option on: open button or enable dropping forces open loop.
// [RULE4] External option off: buttons alone pick open or closed loop.
// [RULE5] Inversion selected: controller output is negated; the code negates it in closed loop only, open loop outputs the bias unnegated.
// [RULE6] Integrator saturation flag high while integrator held at a clamp.
// [RULE7] Output saturation flag high when output at or past either limit.
// [RULE8] Process-high alarm when measured value strictly above high threshold.
// [RULE9] Process-low alarm when measured value strictly below low threshold.
// [RULE10] Analog output routes controller output, measured value or integrator.
// [RULE11] Integrator held at limit until error changes sign.
// [RULE12] Closed loop with drive stopped loads integrator preset.
// [RULE13] Output at upper limit stops integration and holds output there.
// [RULE14] All comparisons re-evaluated every control update.
`timescale 1ns/10ps
module pid_loop_mode_and_alarms
    import pid_aux_pkg::*;
#(
    parameter int W             = DATA_W_DEF,
    parameter int UPDATE_CYCLES = UPDATE_CYCLES_DEF
)
(
    // Clock and reset
    input  wire logic                CLK,
    input  wire logic                SRST,
    // Operator station and external loop select
    input  wire logic                OPEN_BTN,
    input  wire logic                CLOSED_BTN,
    input  wire logic                EXT_ENABLE,
    input  wire logic                EXT_SEL_ON,
    input  wire logic                DRIVE_RUNNING,
    // Controller data
    input  wire logic signed [W-1:0] PD_SUM,
    input  wire logic signed [W-1:0] ERROR,
    input  wire logic signed [W-1:0] BIAS_INPUT,
    input  wire logic signed [W-1:0] MEASURED_VALUE,
    // Configuration
    input  wire logic                INVERT,
    input  wire logic signed [W-1:0] INTEG_PRESET,
    input  wire logic signed [W-1:0] INTEG_UPPER,
    input  wire logic signed [W-1:0] INTEG_LOWER,
    input  wire logic signed [W-1:0] OUT_UPPER,
    input  wire logic signed [W-1:0] OUT_LOWER,
    input  wire logic signed [W-1:0] HIGH_THRESH,
    input  wire logic signed [W-1:0] LOW_THRESH,
    input  wire logic [1:0]          ROUTE_SEL,
    // Outputs
    output logic                     CLOSED_LOOP,
    output logic signed [W-1:0]      CTRL_OUT,
    output logic signed [W-1:0]      INTEG_TERM,
    output logic signed [W-1:0]      ANALOG_OUT,
    output logic                     INTEG_SAT_FLAG,
    output logic                     OUT_SAT_FLAG,
    output logic                     PROCESS_HIGH_ALARM,
    output logic                     PROCESS_LOW_ALARM,
    output logic                     UPDATE_TICK
);

    // Divider is 16 bits wide, so longer update periods cannot be served
    if (W < 4 || W > 32 || UPDATE_CYCLES < 1 || UPDATE_CYCLES > 65536)
    begin : g_param_check
        $error("pid_loop_mode_and_alarms: unsupported parameters");
    end

    //------------------------------------------------------------------
    // Update divider
    //------------------------------------------------------------------
    logic [15:0] div_reg;
    logic        tick;
    assign tick        = (div_reg == 16'(UPDATE_CYCLES - 1));
    assign UPDATE_TICK = tick;

    // Free-running divider making the control update enable
    always_ff @(posedge CLK)
    begin
        if (SRST || tick)
            div_reg <= 16'h0000;
        else
            div_reg <= div_reg + 16'h0001;
    end

    //------------------------------------------------------------------
    // Loop mode
    //------------------------------------------------------------------
    logic closed_reg;
    assign CLOSED_LOOP = closed_reg;

    // Open request wins over closed so a stuck closed button cannot trap auto
    always_ff @(posedge CLK)
    begin
        if (SRST)
            closed_reg <= RST_CLOSED_LOOP;
        else if (OPEN_BTN || (EXT_SEL_ON && !EXT_ENABLE))
            closed_reg <= 1'b0;                         // [RULE3] [RULE4]
        else if (CLOSED_BTN && (!EXT_SEL_ON || EXT_ENABLE))
            closed_reg <= 1'b1;                         // [RULE2] [RULE4]
    end

    //------------------------------------------------------------------
    // Integrator with anti-windup
    //------------------------------------------------------------------
    integ_e             ist_reg;
    logic signed [W-1:0] integ_reg;
    logic signed [W:0]   integ_sum;
    logic signed [W+1:0] raw_sum;
    logic signed [W-1:0] sum_sat;
    logic signed [W-1:0] out_next;
    logic                out_hold;

    assign INTEG_TERM = integ_reg;
    assign integ_sum  = (W+1)'(integ_reg) + (W+1)'(ERROR);
    // Bias shifts the operating point; widened to avoid wrap before clamp
    assign raw_sum    = (W+2)'(PD_SUM) + (W+2)'(integ_reg) + (W+2)'(BIAS_INPUT); // [RULE1]
    assign sum_sat    = (raw_sum >= (W+2)'(OUT_UPPER)) ? OUT_UPPER :
                        (raw_sum <= (W+2)'(OUT_LOWER)) ? OUT_LOWER : W'(raw_sum);
    assign out_hold   = (raw_sum >= (W+2)'(OUT_UPPER));
    assign out_next   = INVERT ? W'(-sum_sat) : sum_sat;  // [RULE5]

    // Integrator, stepped once per update
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            integ_reg <= '0;
            ist_reg   <= INTEG_RUN;
        end
        else if (tick)
        begin
            if (closed_reg && !DRIVE_RUNNING)
            begin
                integ_reg <= INTEG_PRESET;              // [RULE12]
                ist_reg   <= INTEG_RUN;
            end
            else if (!closed_reg)
                ist_reg <= INTEG_RUN;
            else
            begin
                case (ist_reg)
                    INTEG_HOLD_H:
                        if (ERROR < 0)                   // [RULE11]
                        begin
                            ist_reg   <= INTEG_RUN;
                            integ_reg <= W'(integ_sum);
                        end
                    INTEG_HOLD_L:
                        if (ERROR > 0)                   // [RULE11]
                        begin
                            ist_reg   <= INTEG_RUN;
                            integ_reg <= W'(integ_sum);
                        end
                    INTEG_RUN:
                        if (out_hold && ERROR > 0)
                            ist_reg <= INTEG_HOLD_H;     // [RULE13]
                        else if (integ_sum >= (W+1)'(INTEG_UPPER))
                        begin
                            integ_reg <= INTEG_UPPER;    // [RULE11]
                            ist_reg   <= INTEG_HOLD_H;
                        end
                        else if (integ_sum <= (W+1)'(INTEG_LOWER))
                        begin
                            integ_reg <= INTEG_LOWER;    // [RULE11]
                            ist_reg   <= INTEG_HOLD_L;
                        end
                        else
                            integ_reg <= W'(integ_sum);
                    default:
                        ist_reg <= INTEG_RUN;
                endcase
            end
        end
    end

    //------------------------------------------------------------------
    // Output, routing and flags
    //------------------------------------------------------------------
    pid_flags_if flags ();

    pid_compare #(.W(W)) u_cmp
    (
        .ctrl_out    (CTRL_OUT),
        .measured    (MEASURED_VALUE),
        .out_upper   (OUT_UPPER),
        .out_lower   (OUT_LOWER),
        .high_thresh (HIGH_THRESH),
        .low_thresh  (LOW_THRESH),
        .flags       (flags)
    );

    // Output stays clamped at the limit; in open loop the bias alone drives it
    always_ff @(posedge CLK)
    begin
        if (SRST)
            CTRL_OUT <= '0;
        else if (tick)
            CTRL_OUT <= closed_reg ? out_next : BIAS_INPUT; // [RULE13]
    end

    // Analog routing; unused selection reads zero
    always_ff @(posedge CLK)
    begin
        if (SRST)
            ANALOG_OUT <= '0;
        else
        begin
            case (route_e'(ROUTE_SEL))
                ROUTE_CTRL_OUT: ANALOG_OUT <= CTRL_OUT;         // [RULE10]
                ROUTE_MEASURED: ANALOG_OUT <= MEASURED_VALUE;   // [RULE10]
                ROUTE_INTEG:    ANALOG_OUT <= integ_reg;        // [RULE10]
                default:        ANALOG_OUT <= '0;
            endcase
        end
    end

    // Flags sampled on each update; one period latency bounds their lag
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            INTEG_SAT_FLAG     <= RST_FLAG;
            OUT_SAT_FLAG       <= RST_FLAG;
            PROCESS_HIGH_ALARM <= RST_FLAG;
            PROCESS_LOW_ALARM  <= RST_FLAG;
        end
        else if (tick)                                      // [RULE14]
        begin
            INTEG_SAT_FLAG     <= (ist_reg != INTEG_RUN);  // [RULE6]
            OUT_SAT_FLAG       <= flags.out_hi || flags.out_lo; // [RULE7]
            PROCESS_HIGH_ALARM <= flags.proc_hi;           // [RULE8]
            PROCESS_LOW_ALARM  <= flags.proc_lo;           // [RULE9]
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    mode_open_a: assert property (@(posedge CLK) disable iff (SRST)
        OPEN_BTN |=> !CLOSED_LOOP)                                  // [RULE3]
        else $error("open button did not open loop");
    ext_drop_a: assert property (@(posedge CLK) disable iff (SRST)
        (EXT_SEL_ON && !EXT_ENABLE) |=> !CLOSED_LOOP)               // [RULE3]
        else $error("external enable drop ignored");
    ext_close_a: assert property (@(posedge CLK) disable iff (SRST)
        (CLOSED_BTN && !OPEN_BTN && EXT_SEL_ON && EXT_ENABLE) |=> CLOSED_LOOP) // [RULE2]
        else $error("closed loop not entered");
    btn_close_a: assert property (@(posedge CLK) disable iff (SRST)
        (CLOSED_BTN && !OPEN_BTN && !EXT_SEL_ON) |=> CLOSED_LOOP)   // [RULE4]
        else $error("button close failed");
    preset_load_a: assert property (@(posedge CLK) disable iff (SRST)
        (tick && CLOSED_LOOP && !DRIVE_RUNNING) |=> INTEG_TERM == $past(INTEG_PRESET)) // [RULE12]
        else $error("preset not loaded");
    proc_high_a: assert property (@(posedge CLK) disable iff (SRST)
        (tick && MEASURED_VALUE > HIGH_THRESH) |=> PROCESS_HIGH_ALARM) // [RULE8]
        else $error("high alarm missing");
    proc_low_a: assert property (@(posedge CLK) disable iff (SRST)
        (tick && MEASURED_VALUE < LOW_THRESH) |=> PROCESS_LOW_ALARM)   // [RULE9]
        else $error("low alarm missing");
    out_sat_a: assert property (@(posedge CLK) disable iff (SRST)
        (tick && CTRL_OUT >= OUT_UPPER) |=> OUT_SAT_FLAG)           // [RULE7]
        else $error("output saturation missing");
    invert_a: assert property (@(posedge CLK) disable iff (SRST)
        (tick && CLOSED_LOOP && INVERT) |=> CTRL_OUT == W'(-$past(sum_sat))) // [RULE5]
        else $error("inversion wrong");

endmodule

// >>> verif/proc_station.sv
/*
 * Model of the operator station buttons, external enable and transducer.
 * Assumes the bench calls its tasks from code aligned to falling edges.
 */
`timescale 1ns/10ps
module proc_station
    import pid_aux_pkg::*;
#(
    parameter int W = DATA_W_DEF
)
(
    // Clock
    input  wire logic            clk,
    // Buttons and external enable
    output logic                 open_btn,
    output logic                 closed_btn,
    output logic                 ext_enable,
    // Transducer feedback
    output logic signed [W-1:0]  measured
);
    // ----------------------------------------
    // Station actions
    // ----------------------------------------
    // Idle station: nothing pressed, feedback at zero
    initial
    begin
        open_btn = 1'b0;
        closed_btn = 1'b0;
        ext_enable = 1'b0;
        measured = '0;
    end

    // One-cycle press, released before the next sample
    task automatic press(input logic open);
        @(negedge clk);
        open_btn = open;
        closed_btn = !open;
        @(negedge clk);
        open_btn = 1'b0;
        closed_btn = 1'b0;
    endtask

    task automatic set_enable(input logic en);
        ext_enable = en;
    endtask

    task automatic set_pv(input logic signed [W-1:0] v);
        measured = v;
    endtask
endmodule

// >>> verif/tb_pid_loop_mode_and_alarms.sv
/*
 * Self-checking bench: driver notes expectations, a monitor compares them.
 * Assumes UPDATE_CYCLES of 4 and steady inputs for three updates per check; loop-mode checks wait two cycles.
 */
`timescale 1ns/10ps
module tb_pid_loop_mode_and_alarms;
    import pid_aux_pkg::*;
    localparam int UC = 4;
    typedef struct {logic [3:0] k; logic [15:0] v;} note_s;
    logic clk = 1'b0, srst = 1'b1, ext_on = 1'b0, running = 1'b0, inv = 1'b0;
    logic signed [15:0] pd = '0, err = '0, bias = '0, preset = '0, pv, pv_w;
    logic signed [15:0] iu = 16'h0BB8, il = 16'hF448, ou = 16'h1000, ol = 16'hF000;
    logic signed [15:0] hi = 16'h0100, lo = 16'hFF00;
    logic [1:0] route = 2'h0;
    logic open_b, closed_b, en_b, closed, isat, osat, palm_h, palm_l, tick;
    logic signed [15:0] ctrl, integ, analog;
    logic [31:0] rnd = 32'h8DC6;
    logic [15:0] c;
    int errors = 0, num_checks = 0, cycles = 0, s, gap = -1000;
    int bound[5] = '{4096, 4095, -4096, -4095, 6000};
    note_s notes[$];
    note_s n;

    // ----------------------------------------
    // Clock, partner and design
    // ----------------------------------------
    always #4 clk = ~clk;
    proc_station #(.W(16)) station (.clk(clk), .open_btn(open_b), .closed_btn(closed_b),
        .ext_enable(en_b), .measured(pv_w));
    pid_loop_mode_and_alarms #(.W(16), .UPDATE_CYCLES(UC)) dut (.CLK(clk), .SRST(srst),
        .OPEN_BTN(open_b), .CLOSED_BTN(closed_b), .EXT_ENABLE(en_b), .EXT_SEL_ON(ext_on),
        .DRIVE_RUNNING(running), .PD_SUM(pd), .ERROR(err), .BIAS_INPUT(bias),
        .MEASURED_VALUE(pv_w), .INVERT(inv), .INTEG_PRESET(preset), .INTEG_UPPER(iu),
        .INTEG_LOWER(il), .OUT_UPPER(ou), .OUT_LOWER(ol), .HIGH_THRESH(hi),
        .LOW_THRESH(lo), .ROUTE_SEL(route), .CLOSED_LOOP(closed), .CTRL_OUT(ctrl),
        .INTEG_TERM(integ), .ANALOG_OUT(analog), .INTEG_SAT_FLAG(isat),
        .OUT_SAT_FLAG(osat), .PROCESS_HIGH_ALARM(palm_h), .PROCESS_LOW_ALARM(palm_l),
        .UPDATE_TICK(tick));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic note(input logic [3:0] k, input logic [15:0] v);
        notes.push_back(note_s'{k, v});
    endtask

    // Waits until the monitor has consumed every note before inputs move
    task automatic flush(input int upd);
        while (notes.size() > 0) @(negedge clk);
        repeat (upd * UC + 2) @(negedge clk);
    endtask

    task automatic mode(input logic ext, input logic en, input int act, input logic exp);
        station.press(1'b1);
        ext_on = ext;
        station.set_enable(en);
        station.press(1'b0);
        if (act == 1) station.set_enable(1'b0);
        if (act == 2) station.press(1'b1);
        flush(0);
        note(4'h0, {15'h0, exp});
    endtask

    // Monitor: compares the oldest notes with the outputs at a falling edge
    always @(negedge clk)
    begin
        // Update enable spacing; a missing pulse is caught one cycle late
        if (tick === 1'b1)
        begin
            if (gap > 0) check(16'(gap), 16'(UC));
            gap = 0;
        end
        else if (gap == UC + 1)
            check(16'(gap), 16'(UC));
        gap++;
        while (notes.size() > 0)
        begin
            n = notes.pop_front();
            case (n.k)
                4'h0: check(16'(closed), n.v);
                4'h1: check(ctrl, n.v);
                4'h2: check(16'(osat), n.v);
                4'h3: check(16'(palm_h), n.v);
                4'h4: check(16'(palm_l), n.v);
                4'h5: check(analog, n.v);
                4'h6: check(integ, n.v);
                4'h7: check(16'(isat), n.v);
                default: check(16'(integ < iu), n.v);
            endcase
        end
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        for (int k = 0; k < 8; k++) note(4'(k), 16'h0);
        flush(1);
        mode(0, 0, 0, 1); mode(1, 0, 0, 0); mode(1, 1, 0, 1); mode(1, 1, 1, 0);
        mode(1, 1, 2, 0); mode(0, 1, 2, 0); mode(0, 1, 1, 1);
        flush(0);
        $display("test loop mode done");
        rnd = lfsr(rnd);
        preset = 16'(signed'(rnd[10:0]));
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr(rnd);
            bias = 16'(signed'(rnd[10:0]));
            inv = (i >= 5) & rnd[17];
            route = rnd[16:15];
            s = (i < 5) ? bound[i] : int'(signed'(rnd[31:19]));
            pd = 16'(s - preset - bias);
            station.set_pv(16'(signed'(rnd[31:24])));
            flush(3);
            c = 16'((s > ou) ? int'(ou) : (s < ol) ? int'(ol) : s);
            c = inv ? -c : c;
            note(4'h1, c);
            note(4'h6, preset);
            if (!inv) note(4'h2, {15'h0, (s >= ou) || (s <= ol)});
            note(4'h5, (route == 2'h0) ? c : (route == 2'h1) ? pv_w
                : (route == 2'h2) ? preset : 16'h0);
            flush(0);
        end
        $display("test output path done");
        hi = 16'h0100 + 16'(rnd[9:0]);
        lo = -hi;
        for (int j = 0; j < 6; j++)
        begin
            pv = ((j < 3) ? hi : lo) + 16'(j % 3) - 16'h1;
            station.set_pv(pv);
            flush(3);
            note(4'h3, {15'h0, pv > hi});
            note(4'h4, {15'h0, pv < lo});
            flush(0);
        end
        $display("test alarms done");
        flush(0);
        {preset, pd, bias, inv, route, ou} = {48'h0, 1'b0, 2'h0, 16'h7FFF};
        iu = 16'h0800 + 16'(rnd[8:0]);
        flush(3);
        running = 1'b1;
        err = 16'h03E8;
        flush(8);
        note(4'h6, iu);
        note(4'h7, 16'h1);
        flush(0);
        err = 16'hFC18;
        flush(3);
        note(4'h8, 16'h1);
        note(4'h7, 16'h0);
        flush(0);
        err = 16'h03E8;
        ou = 16'h01F4;
        flush(8);
        note(4'h1, ou);
        note(4'h7, 16'h1);
        flush(0);
        // Lower clamp reached with the output pinned at its lower limit
        err = 16'hFC18;
        il = -(16'h0A00 + 16'(rnd[7:0]));
        ol = 16'hF830;
        flush(8);
        note(4'h6, il);
        note(4'h7, 16'h1);
        note(4'h1, ol);
        note(4'h2, 16'h1);
        flush(0);
        // Stopping the drive reloads the preset and clears the hold
        running = 1'b0;
        preset = 16'h0123;
        flush(3);
        note(4'h6, preset);
        note(4'h1, preset);
        note(4'h7, 16'h0);
        flush(0);
        $display("test integrator done");
        give_verdict();
    end
endmodule
